// ### verilog/dph_defines.svh
// constants of the dual-port memory port controller: offsets, fields, resets and timing
`ifndef DPH_DEFINES_SVH
`define DPH_DEFINES_SVH

// ==================================================
// register offsets (byte addresses, one word each)
`define DPH_OFF_CMD     12'h000
`define DPH_OFF_ADDR    12'h004
`define DPH_OFF_WDATA   12'h008
`define DPH_OFF_RDATA   12'h00C
`define DPH_OFF_STATUS  12'h010

// ==================================================
// field positions
`define DPH_CMD_OP_LSB    0
`define DPH_CMD_OP_MSB    1
`define DPH_CMD_UPPER     2
`define DPH_CMD_LOWER     3
`define DPH_ST_ACTIVE     0
`define DPH_ST_DONE       1
`define DPH_ST_GRANTED    2
`define DPH_ST_BUSYSEEN   3

// ==================================================
// reset values
`define DPH_RST_ADDR      32'h0000_0000
`define DPH_RST_WDATA     32'h0000_0000
`define DPH_RST_RDATA     16'h0000

// ==================================================
// timing: figures in ns, counts in cycles of the 250 MHz clock
`define DPH_CLK_MHZ       250
`define DPH_T_ACC_NS      25
`define DPH_T_PWE_NS      20
`define DPH_T_HZ_NS       15
`define DPH_T_SWRD_NS     5
`define DPH_CYC_UP(ns)    (((ns) * `DPH_CLK_MHZ + 999) / 1000)
`define DPH_ACC_CYC       `DPH_CYC_UP(`DPH_T_ACC_NS)
`define DPH_PWE_CYC       `DPH_CYC_UP(`DPH_T_PWE_NS)
`define DPH_HZ_CYC        `DPH_CYC_UP(`DPH_T_HZ_NS)
`define DPH_SWRD_CYC      `DPH_CYC_UP(`DPH_T_SWRD_NS)
`define DPH_SYNC_CYC      2

`endif

// ### verilog/dph_pkg.sv
// types of the dual-port memory port controller
`default_nettype none

package dph_pkg;

	// ==================================================
	// operations that software may order
	typedef enum logic [1:0] {
		DPH_OP_READ,
		DPH_OP_WRITE,
		DPH_OP_SEM_REQ,
		DPH_OP_SEM_REL
	} dph_op_t;

	// ==================================================
	// pins driven towards one memory port (all strobes active low)
	typedef struct packed {
		logic [13:0] addr;
		logic        chipSelN;
		logic        upperByteSelN;
		logic        lowerByteSelN;
		logic        flagSelN;
		logic        writeStrobeN;
		logic        outEnN;
		logic [15:0] dataOut;
		logic [15:0] dataOe;
	} dph_pins_t;

	// ==================================================
	// pins sampled from the memory port
	typedef struct packed {
		logic [15:0] dataIn;
		logic        busyN;
	} dph_pin_in_t;

endpackage : dph_pkg

`default_nettype wire

// ### verilog/dph_sync.sv
// two-flop synchroniser, one per bit
`timescale 1ns/1ps
`default_nettype none

module dph_sync #(
	parameter int WIDTH = 17
) (
	// clock and control
	input  wire logic             clock,
	input  wire logic             resetn,
	input  wire logic             clkEn,
	// asynchronous input and its synchronised copy
	input  wire logic [WIDTH-1:0] async,
	output logic      [WIDTH-1:0] synced
);

	// ==================================================
	// per-bit chain; the first stage feeds only the second
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic meta_r;
			logic sync_r;
			// reset to one so that idle active-low pins read inactive
			always_ff @(posedge clock) begin
				if (!resetn) begin
					meta_r <= 1'b1;
					sync_r <= 1'b1;
				end else if (clkEn) begin
					meta_r <= async[i];
					sync_r <= meta_r;
				end
			end
			assign synced[i] = sync_r;
		end
	endgenerate

endmodule : dph_sync

`default_nettype wire

// ### verilog/dph_host.sv
// host controller for one port of an asynchronous dual-port memory with semaphore flags
// Operation
// - host keeps write strobe high throughout every read of memory or flags.
// - address-only repeated reads serve memory only, never semaphore flags.
// - address is valid no later than chip select falling.
// - upper lane accessed only with chip select low, upper select low, flag select high.
// - lower lane accessed only with chip select low, lower select low, flag select high.
// - host never drives data while device may still drive read data.
// - chip select stays high during semaphore write and its read-back.
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "dph_defines.svh"

module dph_host #(
	parameter int ADDR_W = 14,
	parameter int DATA_W = 16
) (
	// clock, reset, clock enable
	input  wire logic              clock,
	input  wire logic              resetn,
	input  wire logic              clkEn,
	// apb slave
	input  wire logic [11:0]       paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// memory port pins
	output dph_pkg::dph_pins_t     pinOut,
	input  wire dph_pkg::dph_pin_in_t pinIn
);

	// ==================================================
	// cycle counts
	localparam logic [7:0] ACC_WAIT = 8'(`DPH_ACC_CYC + `DPH_SYNC_CYC);
	localparam logic [7:0] PWE_WAIT = 8'(`DPH_PWE_CYC);
	localparam logic [7:0] GAP_WAIT = 8'((`DPH_HZ_CYC > `DPH_SWRD_CYC) ? `DPH_HZ_CYC : `DPH_SWRD_CYC);

	typedef enum logic [2:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_GAP} dph_state_t;

	dph_state_t           state_r;
	dph_pkg::dph_op_t     op_r;
	logic                 upper_r;
	logic                 lower_r;
	logic                 semReadPhase_r;
	logic [7:0]           cnt_r;
	logic [31:0]          addrReg_r;
	logic [31:0]          wdataReg_r;
	logic [DATA_W-1:0]    rdata_r;
	logic                 done_r;
	logic                 granted_r;
	logic                 busySeen_r;
	dph_pkg::dph_pin_in_t pinSync;

	logic apbWr;
	logic apbRd;
	logic mapped;
	logic startCmd;
	logic isSem;
	logic isWrite;

	// ==================================================
	// synchronise data and busy before any logic reads them
	dph_sync #(.WIDTH(DATA_W + 1)) u_sync (
		.clock  (clock),
		.resetn (resetn),
		.clkEn  (clkEn),
		.async  (pinIn),
		.synced (pinSync)
	);

	// ==================================================
	// apb decode: zero-wait slave, error on unmapped offsets
	assign mapped = (paddr == `DPH_OFF_CMD) || (paddr == `DPH_OFF_ADDR) || (paddr == `DPH_OFF_WDATA) ||
	                (paddr == `DPH_OFF_RDATA) || (paddr == `DPH_OFF_STATUS);
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign apbWr   = psel && penable && pwrite && clkEn;
	assign apbRd   = psel && !penable && !pwrite;
	// a command is taken only when idle; later ones are dropped
	assign startCmd = apbWr && (paddr == `DPH_OFF_CMD) && (state_r == S_IDLE);
	assign isSem    = (op_r == dph_pkg::DPH_OP_SEM_REQ) || (op_r == dph_pkg::DPH_OP_SEM_REL);
	assign isWrite  = (op_r == dph_pkg::DPH_OP_WRITE) || (isSem && !semReadPhase_r);

	// ==================================================
	// address and write data registers
	always_ff @(posedge clock) begin
		if (!resetn) begin
			addrReg_r  <= `DPH_RST_ADDR;
			wdataReg_r <= `DPH_RST_WDATA;
		end else if (apbWr && state_r == S_IDLE) begin
			if (paddr == `DPH_OFF_ADDR)
				addrReg_r <= pwdata;
			if (paddr == `DPH_OFF_WDATA)
				wdataReg_r <= pwdata;
		end
	end

	// ==================================================
	// read data register, registered in the setup phase
	always_ff @(posedge clock) begin
		if (!resetn) begin
			prdata <= 32'h0000_0000;
		end else if (clkEn && apbRd) begin
			unique case (paddr)
				`DPH_OFF_CMD:    prdata <= {28'h000_0000, lower_r, upper_r, op_r};
				`DPH_OFF_ADDR:   prdata <= addrReg_r;
				`DPH_OFF_WDATA:  prdata <= wdataReg_r;
				`DPH_OFF_RDATA:  prdata <= {16'h0000, rdata_r};
				`DPH_OFF_STATUS: prdata <= {28'h000_0000, busySeen_r, granted_r, done_r, state_r != S_IDLE};
				default:         prdata <= 32'h0000_0000;
			endcase
		end
	end

	// ==================================================
	// sequencer: setup, strobe, hold, gap
	always_ff @(posedge clock) begin
		if (!resetn) begin
			state_r        <= S_IDLE;
			op_r           <= dph_pkg::DPH_OP_READ;
			upper_r        <= 1'b0;
			lower_r        <= 1'b0;
			semReadPhase_r <= 1'b0;
			cnt_r          <= 8'h00;
		end else if (clkEn) begin
			unique case (state_r)
				S_IDLE: begin
					if (startCmd) begin
						op_r           <= dph_pkg::dph_op_t'(pwdata[`DPH_CMD_OP_MSB:`DPH_CMD_OP_LSB]);
						upper_r        <= pwdata[`DPH_CMD_UPPER];
						lower_r        <= pwdata[`DPH_CMD_LOWER];
						semReadPhase_r <= 1'b0;
						state_r        <= S_SETUP;
					end
				end
				S_SETUP: begin
					cnt_r   <= 8'h00;
					state_r <= S_STROBE;  // address stood a full cycle before select
				end
				S_STROBE: begin
					// a busy memory access holds the count at zero until busy lifts
					if (!isSem && !pinSync.busyN)
						cnt_r <= 8'h00;
					else if (cnt_r == (isWrite ? PWE_WAIT : ACC_WAIT) - 8'h01)
						state_r <= S_HOLD;
					else
						cnt_r <= cnt_r + 8'h01;
				end
				S_HOLD: begin
					cnt_r   <= 8'h00;
					state_r <= S_GAP;
				end
				S_GAP: begin
					// gap covers the device's turn-off time and flag write-to-read
					if (cnt_r == GAP_WAIT - 8'h01) begin
						cnt_r <= 8'h00;
						// flag read-back is a fresh full cycle, never address-only
						if (isSem && !semReadPhase_r) begin
							semReadPhase_r <= 1'b1;
							state_r        <= S_SETUP;
						end else begin
							state_r <= S_IDLE;
						end
					end else begin
						cnt_r <= cnt_r + 8'h01;
					end
				end
			endcase
		end
	end

	// ==================================================
	// pin drive, all from flip-flops
	always_ff @(posedge clock) begin
		if (!resetn) begin
			pinOut <= '{addr: '0, chipSelN: 1'b1, upperByteSelN: 1'b1, lowerByteSelN: 1'b1,
			            flagSelN: 1'b1, writeStrobeN: 1'b1, outEnN: 1'b1, dataOut: '0, dataOe: '0};
		end else if (clkEn) begin
			unique case (state_r)
				S_IDLE: begin
					if (startCmd)
						pinOut.addr <= addrReg_r[ADDR_W-1:0];
				end
				S_SETUP: begin
					// chip select high for flags, low with flag select high for memory
					pinOut.chipSelN      <= isSem;
					pinOut.flagSelN      <= !isSem;
					pinOut.upperByteSelN <= isSem || !upper_r;
					pinOut.lowerByteSelN <= isSem || !lower_r;
					// strobe falls with the selects so the device stays off the bus
					pinOut.writeStrobeN  <= !isWrite;  // high for every read
					pinOut.outEnN        <= isWrite;
					// request writes bit0 low, release writes it high
					if (isSem)
						pinOut.dataOut <= {{(DATA_W-1){1'b0}}, op_r == dph_pkg::DPH_OP_SEM_REL};
					else
						pinOut.dataOut <= wdataReg_r[DATA_W-1:0];
					// data driven only in write cycles, after the preceding gap
					pinOut.dataOe  <= isWrite ? {DATA_W{1'b1}} : {DATA_W{1'b0}};
				end
				S_STROBE: begin
					if (state_r == S_STROBE && cnt_r == (isWrite ? PWE_WAIT : ACC_WAIT) - 8'h01 &&
					    (isSem || pinSync.busyN)) begin
						pinOut.chipSelN      <= 1'b1;
						pinOut.flagSelN      <= 1'b1;
						pinOut.upperByteSelN <= 1'b1;
						pinOut.lowerByteSelN <= 1'b1;
						pinOut.writeStrobeN  <= 1'b1;
						pinOut.outEnN        <= 1'b1;
					end
				end
				S_HOLD: begin
					pinOut.dataOe <= {DATA_W{1'b0}};  // data held one cycle past the strobe
				end
				S_GAP: begin
				end
			endcase
		end
	end

	// ==================================================
	// captured data, grant and status flags
	always_ff @(posedge clock) begin
		if (!resetn) begin
			rdata_r    <= `DPH_RST_RDATA;
			done_r     <= 1'b0;
			granted_r  <= 1'b0;
			busySeen_r <= 1'b0;
		end else if (clkEn) begin
			if (state_r == S_STROBE && !isWrite && cnt_r == ACC_WAIT - 8'h01 && (isSem || pinSync.busyN)) begin
				rdata_r <= pinSync.dataIn;
				// read-back low means this port holds the flag
				if (op_r == dph_pkg::DPH_OP_SEM_REQ)
					granted_r <= !pinSync.dataIn[0];
				if (op_r == dph_pkg::DPH_OP_SEM_REL)
					granted_r <= 1'b0;
			end
			// completion wins over the clear from a new command
			if (state_r == S_GAP && cnt_r == GAP_WAIT - 8'h01 && !(isSem && !semReadPhase_r))
				done_r <= 1'b1;
			else if (startCmd)
				done_r <= 1'b0;
			if (state_r == S_STROBE && !isSem && !pinSync.busyN)
				busySeen_r <= 1'b1;
			else if (startCmd)
				busySeen_r <= 1'b0;
		end
	end

endmodule : dph_host

`default_nettype wire

// ### dv/dph_host_asserts.sv
// assertions on the memory port pins of the dual-port host controller
`timescale 1ns/1ps
`default_nettype none

module dph_host_asserts (
	// clock and reset
	input wire logic                 clock,
	input wire logic                 resetn,
	// bus handshake
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pslverr,
	// memory port
	input wire dph_pkg::dph_pins_t   pinOut,
	input wire dph_pkg::dph_pin_in_t pinIn
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);

	// ==================================================
	// strobe and lane relations
	AST_RD_WE_HIGH: assert property (
		!pinOut.outEnN |-> pinOut.writeStrobeN) else $error("write strobe low during read");
	AST_FLAG_ADDR_HOLD: assert property (
		!pinOut.flagSelN |-> $stable(pinOut.addr)) else $error("address moved in flag access");
	// a flag read-back opens a fresh cycle: flag select falls together with the output enable
	AST_FLAG_FULL_CYCLE: assert property (
		!pinOut.flagSelN && $fell(pinOut.outEnN) |-> $fell(pinOut.flagSelN)) else $error("flag read not a fresh cycle");
	AST_CS_ADDR_HOLD: assert property (
		!pinOut.chipSelN |-> $stable(pinOut.addr)) else $error("address moved while selected");
	AST_UPPER_LANE: assert property (
		!pinOut.chipSelN && !pinOut.writeStrobeN && !pinOut.upperByteSelN |-> pinOut.flagSelN
		&& (&pinOut.dataOe[15:8])) else $error("upper lane write malformed");
	AST_LOWER_LANE: assert property (
		!pinOut.chipSelN && !pinOut.writeStrobeN && !pinOut.lowerByteSelN |-> pinOut.flagSelN
		&& (&pinOut.dataOe[7:0])) else $error("lower lane write malformed");
	// driving data right after a read would fight the device
	AST_NO_FIGHT: assert property (
		pinOut.dataOe != 16'h0000 |-> pinOut.outEnN && $past(pinOut.outEnN)) else $error("data driven in read");
	AST_FLAG_CS_HIGH: assert property (
		!pinOut.flagSelN |-> pinOut.chipSelN) else $error("chip select low in flag access");
	AST_FLAG_BIT0: assert property (
		!pinOut.flagSelN && !pinOut.writeStrobeN |-> pinOut.dataOe[0]) else $error("flag bit not driven");

	// ==================================================
	// main scenarios reached
	cover property ($fell(pinOut.writeStrobeN) && !pinOut.flagSelN);
	cover property (!pinOut.outEnN && !pinIn.busyN);
	cover property (psel && penable && pslverr);
endmodule : dph_host_asserts

bind dph_host dph_host_asserts dph_host_asserts_i (.*);
`default_nettype wire

// ### dv/dph_mem_model.sv
// behavioural model of one port of the dual-port memory with semaphore flags
`timescale 1ns/1ps
`default_nettype none

module dph_mem_model (
	// clock for the idle bus pattern
	input wire logic                 clock,
	// host pins
	input wire dph_pkg::dph_pins_t   pinOut,
	output dph_pkg::dph_pin_in_t     pinIn,
	// far port: flags it holds, busy it raises
	input wire logic [7:0]           otherHeld,
	input wire logic                 busyN
);
	logic [15:0] mem [0:255];
	logic [7:0]  own = 8'h00; // all flags free at start
	logic [15:0] idle = 16'h0000;
	logic        memSel, semSel;

	assign memSel = !pinOut.chipSelN && pinOut.flagSelN;
	assign semSel = pinOut.chipSelN && !pinOut.flagSelN;

	initial for (int i = 0; i < 256; i++) mem[i] = 16'h0000;

	// ==================================================
	// writes land every cycle the strobe is low; a far owner blocks a request
	always @(posedge clock) begin
		idle <= idle + 16'h3C5B; // released bus never holds its last value
		if (!pinOut.writeStrobeN && memSel) begin
			if (!pinOut.upperByteSelN) mem[pinOut.addr[7:0]][15:8] <= pinOut.dataOut[15:8];
			if (!pinOut.lowerByteSelN) mem[pinOut.addr[7:0]][7:0] <= pinOut.dataOut[7:0];
		end
		if (!pinOut.writeStrobeN && semSel)
			own[pinOut.addr[2:0]] <= !pinOut.dataOut[0] && !otherHeld[pinOut.addr[2:0]];
	end

	// ==================================================
	// read drive only with write strobe high; bit 0 low means flag is ours
	always @* begin
		pinIn.busyN = busyN;
		pinIn.dataIn = idle;
		if (!pinOut.outEnN && pinOut.writeStrobeN) begin
			if (memSel && !pinOut.upperByteSelN) pinIn.dataIn[15:8] = mem[pinOut.addr[7:0]][15:8];
			if (memSel && !pinOut.lowerByteSelN) pinIn.dataIn[7:0] = mem[pinOut.addr[7:0]][7:0];
			if (semSel) pinIn.dataIn[0] = !own[pinOut.addr[2:0]];
		end
	end
endmodule : dph_mem_model
`default_nettype wire

// ### dv/dph_host_tb.sv
// self-checking bench of the dual-port memory host controller
`timescale 1ns/1ps
`default_nettype none
`include "dph_defines.svh"

module dph_host_tb;
	logic                 clock = 1'b0;
	logic                 resetn = 1'b0;
	logic [11:0]          paddr = 12'h000;
	logic                 psel = 1'b0;
	logic                 penable = 1'b0;
	logic                 pwrite = 1'b0;
	logic [31:0]          pwdata = 32'h0000_0000;
	logic [31:0]          prdata, q, st;
	logic                 pready, pslverr, err;
	dph_pkg::dph_pins_t   pinOut;
	dph_pkg::dph_pin_in_t pinIn;
	logic [7:0]           otherHeld = 8'h00;
	logic                 busyN = 1'b1;
	logic                 clkEn = 1'b1;
	int                   failures = 0;
	int                   n_tests = 0;
	int                   cycles = 0;

	always #2 clock = ~clock;

	dph_host dph_host_i (.clock(clock), .resetn(resetn), .clkEn(clkEn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pinOut(pinOut), .pinIn(pinIn));
	dph_mem_model dph_mem_model_i (.clock(clock), .pinOut(pinOut), .pinIn(pinIn),
		.otherHeld(otherHeld), .busyN(busyN));

	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim

	// a hang counts as a mismatch
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			$display("[FAIL] %0t timeout", $time);
			end_sim();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk

	// ==================================================
	// one bus transfer: setup, then access until pready
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		@(posedge clock);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1) @(posedge clock);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic poll;
		st = 32'h0000_0000;
		while (st[1] !== 1'b1) apb(`DPH_OFF_STATUS, 1'b0, 32'h0000_0000, st, err);
	endtask : poll

	// cmd is {lower lane, upper lane, op}
	task automatic op(input logic [3:0] c, input logic [13:0] a, input logic [15:0] d);
		apb(`DPH_OFF_ADDR, 1'b1, {18'h0_0000, a}, q, err);
		apb(`DPH_OFF_WDATA, 1'b1, {16'h0000, d}, q, err);
		apb(`DPH_OFF_CMD, 1'b1, {28'h000_0000, c}, q, err);
		poll();
	endtask : op

	task automatic rdat(input logic [31:0] exp, input string what);
		apb(`DPH_OFF_RDATA, 1'b0, 32'h0000_0000, q, err);
		chk(q, exp, what);
	endtask : rdat

	// ==================================================
	// scenarios
	task automatic t_reset;
		apb(`DPH_OFF_STATUS, 1'b0, 32'h0000_0000, q, err);
		chk(q, 32'h0000_0000, "status after reset");
		rdat(32'h0000_0000, "read data after reset");
	endtask : t_reset

	task automatic t_mem;
		op(4'hD, 14'h0123, 16'hA55A);
		op(4'hC, 14'h0123, 16'h0000);
		rdat(32'h0000_A55A, "full word");
		op(4'h5, 14'h0123, 16'h12FF);
		op(4'h9, 14'h0123, 16'hEE34);
		op(4'hC, 14'h0123, 16'h0000);
		rdat(32'h0000_1234, "single lanes");
	endtask : t_mem

	task automatic t_sem;
		otherHeld <= 8'h08;
		op(4'h2, 14'h0002, 16'h0000);
		chk(st & 32'h0000_0004, 32'h0000_0004, "free flag granted");
		op(4'h2, 14'h0003, 16'h0000);
		chk(st & 32'h0000_0004, 32'h0000_0000, "flag held by far port");
		op(4'h3, 14'h0002, 16'h0001);
		chk(st & 32'h0000_0004, 32'h0000_0000, "flag released");
		otherHeld <= 8'h04;
		op(4'h2, 14'h0002, 16'h0000);
		chk(st & 32'h0000_0004, 32'h0000_0000, "released flag taken by far port");
	endtask : t_sem

	task automatic t_busy;
		busyN <= 1'b0;
		apb(`DPH_OFF_ADDR, 1'b1, 32'h0000_0123, q, err);
		apb(`DPH_OFF_CMD, 1'b1, 32'h0000_000C, q, err);
		repeat (20) @(posedge clock);
		busyN <= 1'b1;
		poll();
		chk(st & 32'h0000_0008, 32'h0000_0008, "busy seen");
		rdat(32'h0000_1234, "data after busy");
	endtask : t_busy

	task automatic t_refuse;
		apb(`DPH_OFF_CMD, 1'b1, 32'h0000_000C, q, err);
		apb(`DPH_OFF_ADDR, 1'b1, 32'h0000_0050, q, err);
		poll();
		apb(`DPH_OFF_CMD, 1'b1, 32'h0000_000C, q, err);
		poll();
		rdat(32'h0000_1234, "address kept while active");
		apb(12'h020, 1'b1, 32'h0000_FFFF, q, err);
		chk({31'h0000_0000, err}, 32'h0000_0001, "unmapped write error");
		apb(12'h020, 1'b0, 32'h0000_0000, q, err);
		chk(q, 32'h0000_0000, "unmapped read");
	endtask : t_refuse

	// clock enable low freezes a running read mid-strobe; then a reset in mid-run clears everything
	task automatic t_freeze;
		dph_pkg::dph_pins_t frozen;
		apb(`DPH_OFF_CMD, 1'b1, 32'h0000_000C, q, err);
		repeat (4) @(posedge clock);
		clkEn <= 1'b0;
		@(posedge clock);
		frozen = pinOut;
		repeat (30) @(posedge clock);
		chk({31'h0000_0000, pinOut == frozen}, 32'h0000_0001, "pins frozen");
		clkEn <= 1'b1;
		poll();
		rdat(32'h0000_1234, "data after freeze");
		apb(`DPH_OFF_CMD, 1'b1, 32'h0000_000C, q, err);
		repeat (3) @(posedge clock);
		resetn <= 1'b0;
		repeat (2) @(posedge clock);
		resetn <= 1'b1;
		@(posedge clock);
		chk({28'h000_0000, pinOut.chipSelN, pinOut.writeStrobeN, pinOut.outEnN, pinOut.dataOe == 16'h0000},
			32'h0000_000F, "pins idle after mid-run reset");
		apb(`DPH_OFF_STATUS, 1'b0, 32'h0000_0000, q, err);
		chk(q, 32'h0000_0000, "status after mid-run reset");
		rdat(32'h0000_0000, "read data after mid-run reset");
	endtask : t_freeze

	initial begin
		repeat (12) @(posedge clock);
		resetn <= 1'b1;
		t_reset();
		t_mem();
		t_sem();
		t_busy();
		t_refuse();
		t_freeze();
		end_sim();
	end
endmodule : dph_host_tb
`default_nettype wire
